// >>> logic/abp_pkg.sv
package abp_pkg;
  localparam int PORTS = 16;
  localparam int RACKS = 255;
  localparam int LABEL_MAX = 13;
  localparam int FWREV_MAX = 14;
  // register byte addresses
  localparam logic [7:0] A_ID = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_SESS = 8'h08;
  localparam logic [7:0] A_SYSG = 8'h0c;
  localparam logic [7:0] A_RACKG = 8'h10;
  localparam logic [7:0] A_PSEL = 8'h14;
  localparam logic [7:0] A_PVLEN = 8'h18;
  localparam logic [7:0] A_PVEC = 8'h1c;
  localparam logic [7:0] A_GRP0 = 8'h20;
  localparam logic [7:0] A_GRP1 = 8'h24;
  localparam logic [7:0] A_LBL = 8'h30;
  localparam logic [7:0] A_FW = 8'h40;
  // selection codes: X/empty, A, B
  localparam logic [1:0] ST_X = 2'h0;
  localparam logic [1:0] ST_A = 2'h1;
  localparam logic [1:0] ST_B = 2'h2;
  localparam logic [7:0] RACK_MASTER = 8'h01;
  localparam logic [7:0] RACK_BAD = 8'h00;
  // session register fields
  localparam int SESS_LOGIN = 0;
  localparam int SESS_LOGOFF = 1;
  localparam int SESS_RESET = 2;
  localparam int SESS_KEY = 8;
  // event codes
  localparam logic [2:0] EV_COLD = 3'h0;
  localparam logic [2:0] EV_AUTH = 3'h4;
  localparam logic [2:0] EV_KEY = 3'h1;
  localparam logic [2:0] EV_RGANG = 3'h2;
  localparam logic [2:0] EV_PORT = 3'h4;
  localparam logic [2:0] EV_SGANG = 3'h6;
  localparam logic [2:0] EV_SUPPLY = 3'h7;
  // reset values and other constants
  localparam logic [15:0] SEL_RST = 16'h0000;
  localparam logic [63:0] GRP_RST = 64'h0;
  localparam logic [63:0] GRP_PAIRED = 64'h8765_4321_8765_4321;
  localparam logic [31:0] LBL_LAST_MASK = 32'h0000_00ff;
  localparam logic [31:0] FW_LAST_MASK = 32'h0000_ffff;
  localparam logic [7:0] BUSY_CYC = 8'h04;
  localparam logic [7:0] LOGIN_KEY = 8'h5a;
  typedef struct packed {
    logic [7:0] rack_addr;
    logic [15:0] populated;
    logic [15:0] panel_b;
    logic key_on;
    logic gang_in;
    logic pwr1;
    logic pwr2;
  } abp_pins_s;
  typedef struct packed {
    logic valid;
    logic generic;
    logic [2:0] code;
  } abp_evt_s;
endpackage

// >>> logic/abp_core.sv
`timescale 1ns/1ps
// Behaviour
// - only one management session open; a second login is refused
// - reset command closes any open session
// - command during processing hangs the device until a valid login or a reset command
// - system gang drives every port; racks 1..255, 16 ports each
// - system gang read answered only when rack address is 0x01
// - system status: A if any A, B if all B, empty if none
// - rack gang drives all ports; readback A, B or empty
// - rack address from eight-bit switches, read-only, 0x00 invalid
// - key-lock off ignores front-panel switches; key state readable
// - gang chain input and commands act regardless of key-lock
// - supply state: both inputs good, or one supply lost
// - rack label holds at most 13 characters
// - firmware revision text read-only, at most 14 characters
// - port vector read: ports 1..16, unpopulated shown as X
// - port vector write: A or B sets, X leaves port unchanged
// - one-character vector write acts as a port selection write
// - multi-character vector write bypasses the group map
// - eight-lead variant forces ports 9..16 to follow ports 1..8
// - no vector write breaks the eight-lead pairing
// - events carry the documented generic and specific codes
// - group map: one nibble per port, 0 independent, groups follow
// - selection A joins common to A, B to B; readback A/B/empty
module abp_core #(
  parameter bit EIGHT_LEAD = 1'b0,
  parameter logic [111:0] FW_REV = 112'h0,
  parameter logic [7:0] KEY = abp_pkg::LOGIN_KEY,
  parameter logic [7:0] PROC_CYC = abp_pkg::BUSY_CYC
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // rack pins
  input wire abp_pkg::abp_pins_s PINS,
  output logic [15:0] SEL_B,
  output logic GANG_OUT,
  // events
  output abp_pkg::abp_evt_s EVT
);
  import abp_pkg::*;

  function automatic logic [15:0] grp_apply(input logic [15:0] s, input logic [3:0] p,
                                            input logic b, input logic [63:0] g);
    logic [15:0] r;
    logic [3:0] gp;
    r = s;
    gp = g[4*p +: 4];
    for (int i = 0; i < 16; i++) begin
      if (4'(i) == p || (gp != 4'h0 && g[4*i +: 4] == gp)) begin
        r[i] = b;
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] agg(input logic [15:0] s, input logic [15:0] pop);
    if (pop == 16'h0) begin
      return ST_X;
    end
    return (|(~s & pop)) ? ST_A : ST_B;
  endfunction

  ////////////////////////////////////////////////////////////
  // pin synchroniser and edges
  abp_pins_s pins_m_r, pins_s_r, pins_p_r;
  logic [1:0] warm_r;
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      pins_m_r <= '0;
      pins_s_r <= '0;
      pins_p_r <= '0;
      warm_r <= 2'h0;
    end else if (CE) begin
      pins_m_r <= PINS;
      pins_s_r <= pins_m_r;
      pins_p_r <= pins_s_r;
      warm_r <= warm_r + {1'b0, ~&warm_r};
    end
  end
  wire logic [7:0] rack_id = pins_s_r.rack_addr;
  wire logic [15:0] pop = pins_s_r.populated;
  // no false edges until both stages hold real pin values
  wire logic live = warm_r == 2'h3;
  wire logic gang_edge = live & (pins_s_r.gang_in != pins_p_r.gang_in);
  wire logic [15:0] panel_edge = {16{live}} & (pins_s_r.panel_b ^ pins_p_r.panel_b);
  wire logic key_edge = live & (pins_s_r.key_on != pins_p_r.key_on);
  wire logic pwr_edge = live & ({pins_s_r.pwr1, pins_s_r.pwr2} != {pins_p_r.pwr1, pins_p_r.pwr2});

  ////////////////////////////////////////////////////////////
  // state
  logic [15:0] sel_r, sel_nxt;
  logic [63:0] grp_r;
  logic [31:0] lbl_r [4];
  logic sess_r, sess_nxt, hung_r, hung_nxt, cold_r;
  logic [7:0] busy_r;
  logic [4:0] vlen_r;
  logic [3:0] pidx_r;
  logic pready_r, pslverr_r, gang_out_r;
  logic [31:0] prdata_r, rdata;
  abp_evt_s evt_r, evt_nxt;

  ////////////////////////////////////////////////////////////
  // apb decode
  wire logic acc = PSEL & PENABLE;
  wire logic prep = acc & ~pready_r;
  wire logic take = acc & pready_r;
  wire logic wr = take & PWRITE;
  wire logic hit_sess = PADDR == A_SESS;
  wire logic hit_sysg = PADDR == A_SYSG;
  wire logic hit_rackg = PADDR == A_RACKG;
  wire logic hit_psel = PADDR == A_PSEL;
  wire logic hit_pvlen = PADDR == A_PVLEN;
  wire logic hit_pvec = PADDR == A_PVEC;
  wire logic hit_grp = PADDR[7:3] == A_GRP0[7:3];
  wire logic hit_lbl = PADDR[7:4] == A_LBL[7:4];
  wire logic hit_fw = PADDR[7:4] == A_FW[7:4];
  wire logic is_cmd = hit_sysg | hit_rackg | hit_psel | hit_pvlen | hit_pvec | hit_grp | hit_lbl;
  wire logic idle = busy_r == 8'h0;
  wire logic cmd_ok = sess_r & ~hung_r & idle;
  wire logic [31:0] wd = PWDATA;
  wire logic wd_ab = wd[1:0] == ST_A || wd[1:0] == ST_B;
  wire logic wd_b = wd[1:0] == ST_B;
  wire logic login = hit_sess & wd[SESS_LOGIN];
  wire logic key_ok = wd[SESS_KEY +: 8] == KEY;
  wire logic logoff = hit_sess & wd[SESS_LOGOFF];
  wire logic rst_cmd = hit_sess & wd[SESS_RESET];
  wire logic login_refuse = login & key_ok & sess_r & ~hung_r;
  wire logic grp_lock = EIGHT_LEAD & hit_grp;
  wire logic ro_wr = hit_fw | PADDR == A_ID | PADDR == A_STAT;
  wire logic sys_deaf = ~PWRITE & hit_sysg & rack_id != RACK_MASTER;
  wire logic known = is_cmd | hit_sess | hit_fw | PADDR == A_ID | PADDR == A_STAT;
  wire logic err_w = ~known | (PWRITE & ((is_cmd & ~cmd_ok) | ro_wr | grp_lock | login_refuse
                     | (login & ~key_ok))) | sys_deaf;
  wire logic go = wr & is_cmd & cmd_ok;
  wire logic clash = wr & is_cmd & sess_r & ~hung_r & ~idle;
  wire logic [63:0] grp_w = EIGHT_LEAD ? GRP_PAIRED : grp_r;

  ////////////////////////////////////////////////////////////
  // port selection next state
  logic ev_port, ev_rgang, ev_sgang;
  always_comb begin
    sel_nxt = sel_r;
    ev_port = 1'b0;
    ev_rgang = 1'b0;
    ev_sgang = 1'b0;
    if (gang_edge) begin
      sel_nxt = {16{pins_s_r.gang_in}};
      ev_sgang = 1'b1;
    end
    if (pins_s_r.key_on) begin
      for (int i = 0; i < 16; i++) begin
        if (panel_edge[i]) begin
          sel_nxt = grp_apply(sel_nxt, 4'(i), pins_s_r.panel_b[i], grp_w);
          ev_port = 1'b1;
        end
      end
    end
    if (go & wd_ab & hit_sysg) begin
      sel_nxt = {16{wd_b}};
      ev_sgang = 1'b1;
    end
    if (go & wd_ab & hit_rackg) begin
      sel_nxt = {16{wd_b}};
      ev_rgang = 1'b1;
    end
    if (go & wd_ab & hit_psel) begin
      sel_nxt = grp_apply(sel_r, wd[11:8], wd_b, grp_w);
      ev_port = 1'b1;
    end
    if (go & hit_pvec) begin
      if (vlen_r == 5'd1) begin
        if (wd_ab) begin
          sel_nxt = grp_apply(sel_r, 4'h0, wd_b, grp_w);
        end
      end else begin
        for (int i = 0; i < 16; i++) begin
          if (5'(i) < vlen_r && wd[2*i +: 2] == ST_A) begin
            sel_nxt[i] = 1'b0;
          end else if (5'(i) < vlen_r && wd[2*i +: 2] == ST_B) begin
            sel_nxt[i] = 1'b1;
          end
        end
      end
      ev_port = 1'b1;
    end
    if (EIGHT_LEAD) begin
      sel_nxt[15:8] = sel_nxt[7:0];
    end
  end

  ////////////////////////////////////////////////////////////
  // session
  always_comb begin
    sess_nxt = sess_r;
    hung_nxt = hung_r;
    if (wr & login & key_ok & (~sess_r | hung_r)) begin
      sess_nxt = 1'b1;
      hung_nxt = 1'b0;
    end else if (wr & logoff & ~hung_r) begin
      sess_nxt = 1'b0;
    end
    if (clash) begin
      hung_nxt = 1'b1;
    end
    if (wr & rst_cmd) begin
      sess_nxt = 1'b0;
      hung_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // events, highest priority first
  always_comb begin
    evt_nxt = '0;
    if (!cold_r) begin
      evt_nxt = '{1'b1, 1'b1, EV_COLD};
    end else if (wr & login & ~key_ok) begin
      evt_nxt = '{1'b1, 1'b1, EV_AUTH};
    end else if (key_edge) begin
      evt_nxt = '{1'b1, 1'b0, EV_KEY};
    end else if (pwr_edge) begin
      evt_nxt = '{1'b1, 1'b0, EV_SUPPLY};
    end else if (ev_sgang) begin
      evt_nxt = '{1'b1, 1'b0, EV_SGANG};
    end else if (ev_rgang) begin
      evt_nxt = '{1'b1, 1'b0, EV_RGANG};
    end else if (ev_port) begin
      evt_nxt = '{1'b1, 1'b0, EV_PORT};
    end
  end

  ////////////////////////////////////////////////////////////
  // read mux
  logic [31:0] pvec_rd;
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pvec_rd[2*i +: 2] = !pop[i] ? ST_X : sel_r[i] ? ST_B : ST_A;
    end
  end
  wire logic [31:0] fw_w [4] = '{FW_REV[31:0], FW_REV[63:32], FW_REV[95:64],
                                 {16'h0, FW_REV[111:96]} & FW_LAST_MASK};
  always_comb begin
    rdata = 32'h0;
    case (PADDR)
      A_ID: rdata = {23'h0, rack_id != RACK_BAD, rack_id};
      A_STAT: rdata = {24'h0, ~idle, hung_r, sess_r, pins_s_r.pwr1 & pins_s_r.pwr2,
                       pins_s_r.pwr1, pins_s_r.pwr2, pins_s_r.key_on, 1'b0};
      A_SESS: rdata = {30'h0, hung_r, sess_r};
      A_SYSG: rdata = sys_deaf ? 32'h0 : {30'h0, agg(sel_r, pop)};
      A_RACKG: rdata = {30'h0, agg(sel_r, pop)};
      A_PSEL: rdata = {20'h0, pidx_r, 6'h0, !pop[pidx_r] ? ST_X : sel_r[pidx_r] ? ST_B : ST_A};
      A_PVLEN: rdata = {27'h0, vlen_r};
      A_PVEC: rdata = pvec_rd;
      A_GRP0: rdata = grp_w[31:0];
      A_GRP1: rdata = grp_w[63:32];
      default: begin
        if (hit_lbl) begin
          rdata = lbl_r[PADDR[3:2]];
        end else if (hit_fw) begin
          rdata = fw_w[PADDR[3:2]];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else if (CE) begin
      pready_r <= prep;
      pslverr_r <= prep & err_w;
      prdata_r <= prep ? rdata : 32'h0;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      sel_r <= SEL_RST;
      sess_r <= 1'b0;
      hung_r <= 1'b0;
      cold_r <= 1'b0;
      evt_r <= '0;
      gang_out_r <= 1'b0;
    end else if (CE) begin
      sel_r <= sel_nxt;
      sess_r <= sess_nxt;
      hung_r <= hung_nxt;
      cold_r <= 1'b1;
      evt_r <= evt_nxt;
      gang_out_r <= ev_sgang ? sel_nxt[0] : gang_out_r;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      busy_r <= 8'h0;
      vlen_r <= 5'd16;
      pidx_r <= 4'h0;
      grp_r <= GRP_RST;
    end else if (CE) begin
      busy_r <= go ? PROC_CYC : idle ? 8'h0 : busy_r - 8'h1;
      if (go & hit_pvlen) begin
        vlen_r <= (wd[4:0] > 5'd16 || wd[4:0] == 5'd0) ? 5'd16 : wd[4:0];
      end
      if (go & hit_psel) begin
        pidx_r <= wd[11:8];
      end
      if (go & hit_grp & ~EIGHT_LEAD) begin
        grp_r[32*PADDR[2] +: 32] <= wd;
      end
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_lbl
    always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
        lbl_r[g] <= 32'h0;
      end else if (CE && go && hit_lbl && PADDR[3:2] == 2'(g)) begin
        lbl_r[g] <= (g == 3) ? (wd & LBL_LAST_MASK) : wd;
      end
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign SEL_B = sel_r;
  assign GANG_OUT = gang_out_r;
  assign EVT = evt_r;

  ////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  chk_one_session: assert property (CE && prep && PWRITE && login_refuse |=> PSLVERR ##1 sess_r)
    else $error("second session accepted");
  chk_reset_frees: assert property (CE && wr && rst_cmd |=> !sess_r && !hung_r)
    else $error("reset command left session open");
  chk_hung_holds: assert property (CE && hung_r && !(wr && ((login && key_ok) || rst_cmd)) |=> hung_r)
    else $error("hang released without login");
  chk_sys_all: assert property (CE && go && hit_sysg && wd_ab |=> sel_r == {16{$past(wd_b)}})
    else $error("system gang missed a port");
  chk_sys_deaf: assert property (CE && prep && !PWRITE && hit_sysg && rack_id != RACK_MASTER |=> PSLVERR)
    else $error("non-master rack answered system read");
  chk_key_gate: assert property (CE && !pins_s_r.key_on && !gang_edge && !go |=> $stable(sel_r))
    else $error("panel acted while key-lock off");
  chk_gang_in: assert property (CE && gang_edge && !go |=> sel_r == {16{$past(pins_s_r.gang_in)}})
    else $error("gang input ignored");
  chk_eight_pair: assert property (EIGHT_LEAD |-> SEL_B[15:8] == SEL_B[7:0])
    else $error("eight-lead pairing broken");
  chk_label_cap: assert property (lbl_r[3][31:8] == 24'h0)
    else $error("label longer than limit");
  chk_cold_event: assert property (CE && !cold_r |=> EVT.valid && EVT.generic && EVT.code == EV_COLD)
    else $error("cold start event missing");

  cov_login: cover property (CE && wr && login && key_ok ##[1:20] go);
  cov_hang: cover property (clash ##[1:50] (wr && login && key_ok));
  cov_vec: cover property (go && hit_pvec && vlen_r > 5'd1);
  cov_panel: cover property (pins_s_r.key_on && |panel_edge);
endmodule // abp_core

// >>> verif/abp_mgr_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// apb manager standing on the far side of the register bus
module abp_mgr_model (
  // clock
  input wire logic clk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // blocking, one command at a time
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data must not keep its last value
    pwdata <= ~d;
  endtask
endmodule // abp_mgr_model

// >>> verif/ab_port_gang_status_control_tb.sv
`timescale 1ns/1ps
module ab_port_gang_status_control_tb;
  import abp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, gang_out, erv, cold_got = 1'b0, ev_seen = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv, v, seed = 32'h0eff3447;
  logic [15:0] sel_b, exp_sel, pop, sel8;
  abp_pins_s pins;
  abp_evt_s evt, ev_last, cold_ev;
  int miscompares = 0;
  int comparisons = 0;
  int gap = 25;

  always #2.5 clk = ~clk;

  abp_core #(.FW_REV({112{1'b1}}), .PROC_CYC(8'h14)) dut (.REF_CLK(clk), .RESET(rst), .CE(1'b1),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PINS(pins), .SEL_B(sel_b), .GANG_OUT(gang_out), .EVT(evt));
  abp_core #(.EIGHT_LEAD(1'b1), .PROC_CYC(8'h14)) dut_pair (.REF_CLK(clk), .RESET(rst), .CE(1'b1),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(),
    .PREADY(), .PSLVERR(), .PINS(pins), .SEL_B(sel8), .GANG_OUT(), .EVT());
  abp_mgr_model mgr (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  always @(posedge clk) begin
    if (evt.valid === 1'b1) begin
      ev_last <= evt;
      ev_seen <= 1'b1;
      if (!cold_got) cold_ev <= evt;
      cold_got <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] agg(input logic [15:0] p, input logic [15:0] s);
    if (p == 16'h0) return {30'h0, ST_X};
    if ((p & ~s) != 16'h0) return {30'h0, ST_A};
    return {30'h0, ST_B};
  endfunction
  function automatic logic [31:0] fixv(input logic [31:0] d);
    fixv = d;
    for (int i = 0; i < 16; i++) if (d[2*i+:2] == 2'h3) fixv[2*i+:2] = ST_A;
  endfunction
  function automatic logic [15:0] apply(input logic [15:0] s, input logic [31:0] d);
    for (int i = 0; i < 16; i++) begin
      if (d[2*i+:2] == ST_A) s[i] = 1'b0;
      else if (d[2*i+:2] == ST_B) s[i] = 1'b1;
    end
    return s;
  endfunction
  function automatic logic [31:0] vec_of(input logic [15:0] p, input logic [15:0] s);
    vec_of = 32'h0;
    for (int i = 0; i < 16; i++) if (p[i]) vec_of[2*i+:2] = s[i] ? ST_B : ST_A;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    mgr.xfer(1'b1, a, d, rdv, erv);
    check({31'h0, erv}, {31'h0, e});
    repeat (gap) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
    mgr.xfer(1'b0, a, 32'h0, rdv, erv);
    check(rdv, exp);
    check({31'h0, erv}, {31'h0, e});
  endtask
  task automatic ev(input logic g, input logic [2:0] c);
    check({27'h0, ev_seen, ev_last.generic, ev_last.code}, {27'h0, 1'b1, g, c});
    ev_seen = 1'b0;
  endtask
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask
  task automatic sel_is(input logic [15:0] e);
    check({16'h0, sel_b & pop}, {16'h0, e & pop});
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    pins = '0;
    pins.rack_addr = RACK_MASTER;
    pins.populated = 16'hffff;
    pins.key_on = 1'b1;
    pins.pwr1 = 1'b1;
    pins.pwr2 = 1'b1;
    pop = 16'hffff;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle();
    check({27'h0, cold_got, cold_ev.generic, cold_ev.code}, {27'h0, 1'b1, 1'b1, EV_COLD});
    sel_is(SEL_RST);
    rd(A_STAT, 32'h1e, 1'b0);
    rd(A_ID, 32'h101, 1'b0);
    wr(A_ID, 32'h0, 1'b1);
    wr(8'h80, 32'h0, 1'b1);
    $display("test reset done");
    wr(A_SYSG, 32'h2, 1'b1);
    wr(A_SESS, 32'h3301, 1'b1);
    ev(1'b1, EV_AUTH);
    wr(A_SESS, 32'h5a01, 1'b0);
    wr(A_SESS, 32'h5a01, 1'b1);
    wr(A_SESS, 32'h4, 1'b0);
    rd(A_SESS, 32'h0, 1'b0);
    wr(A_SESS, 32'h5a01, 1'b0);
    $display("test session done");
    wr(A_SYSG, {30'h0, ST_B}, 1'b0);
    ev(1'b0, EV_SGANG);
    check({15'h0, gang_out, sel_b}, 32'h1ffff);
    v = rnd();
    pins.populated <= v[15:0];
    pop = v[15:0];
    settle();
    rd(A_SYSG, agg(pop, 16'hffff), 1'b0);
    pins.rack_addr <= v[23:16] | 8'h02;
    settle();
    rd(A_SYSG, 32'h0, 1'b1);
    rd(A_ID, {23'h0, 1'b1, v[23:16] | 8'h02}, 1'b0);
    pins.rack_addr <= RACK_MASTER;
    settle();
    wr(A_RACKG, {30'h0, ST_A}, 1'b0);
    ev(1'b0, EV_RGANG);
    exp_sel = 16'h0;
    sel_is(exp_sel);
    rd(A_RACKG, agg(pop, exp_sel), 1'b0);
    $display("test gang done");
    wr(A_GRP0, 32'h11, 1'b0);
    wr(A_PVLEN, 32'h10, 1'b0);
    for (int k = 0; k < 8; k++) begin
      v = fixv(rnd());
      exp_sel = apply(exp_sel, v);
      wr(A_PVEC, v, 1'b0);
      sel_is(exp_sel);
      check({16'h0, sel8}, {16'h0, exp_sel[7:0], exp_sel[7:0]});
      rd(A_PVEC, vec_of(pop, exp_sel), 1'b0);
    end
    pins.populated <= 16'hffff;
    pop = 16'hffff;
    settle();
    wr(A_PSEL, {30'h0, ST_A}, 1'b0);
    exp_sel[1:0] = 2'b00;
    sel_is(exp_sel);
    wr(A_PVLEN, 32'h1, 1'b0);
    ev_seen = 1'b0;
    wr(A_PVEC, {30'h0, ST_B}, 1'b0);
    ev(1'b0, EV_PORT);
    exp_sel[1:0] = 2'b11;
    sel_is(exp_sel);
    rd(A_PSEL, {30'h0, ST_B}, 1'b0);
    $display("test vector done");
    pins.key_on <= 1'b0;
    settle();
    ev(1'b0, EV_KEY);
    rd(A_STAT, 32'h3c, 1'b0);
    pins.panel_b <= 16'hffff;
    settle();
    sel_is(exp_sel);
    pins.gang_in <= 1'b1;
    settle();
    ev(1'b0, EV_SGANG);
    sel_is(16'hffff);
    pins.key_on <= 1'b1;
    settle();
    pins.panel_b <= 16'hfffe;
    settle();
    sel_is(16'hfffc);
    pins.pwr2 <= 1'b0;
    settle();
    ev(1'b0, EV_SUPPLY);
    rd(A_STAT, 32'h2a, 1'b0);
    $display("test pins done");
    wr(A_LBL + 8'h0c, 32'hffffffff, 1'b0);
    rd(A_LBL + 8'h0c, 32'h000000ff, 1'b0);
    wr(A_FW, 32'h0, 1'b1);
    rd(A_FW + 8'h0c, 32'h0000ffff, 1'b0);
    gap = 0;
    wr(A_SYSG, {30'h0, ST_A}, 1'b0);
    wr(A_RACKG, {30'h0, ST_A}, 1'b1);
    gap = 25;
    wr(A_SYSG, {30'h0, ST_A}, 1'b1);
    rd(A_SESS, 32'h3, 1'b0);
    wr(A_SESS, 32'h5a01, 1'b0);
    wr(A_SYSG, {30'h0, ST_B}, 1'b0);
    $display("test text and busy done");
    conclude();
  end
endmodule // ab_port_gang_status_control_tb
